// file: hdl/messaging_block_pkg.sv
// package: shared types and constants for the message doorbell unit
package messaging_block_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int NUM_MSG = 2;
    localparam int NUM_DIR = 2;
    localparam int NUM_Q = 4;
    localparam int Q_DEPTH = 16;
    localparam int IDX_W = 2;

    // ************************************************************
    // direction and side numbering
    // ************************************************************
    // direction 0 carries host to core, direction 1 core to host
    localparam int DIR_IN = 0;
    localparam int DIR_OUT = 1;
    localparam int SIDE_HOST = 0;
    localparam int SIDE_CORE = 1;

    // ************************************************************
    // reset values and codes
    // ************************************************************
    localparam logic [DATA_W-1:0] WORD_RST = 32'h0000_0000;
    localparam logic [BE_W-1:0] BE_FULL = 4'hf;

    // ************************************************************
    // access targets and request carrier
    // ************************************************************
    typedef enum logic [1:0] {
        TGT_DOORBELL,
        TGT_DB_CLEAR,
        TGT_MESSAGE,
        TGT_QUEUE
    } target_t;

    typedef struct packed {
        logic wr;
        logic rd;
        target_t tgt;
        logic [IDX_W-1:0] idx;
        logic [BE_W-1:0] be;
        logic [DATA_W-1:0] data;
    } req_t;

endpackage

// file: hdl/msg_fifo.sv
// file: parameterised word fifo with registered read data
`timescale 1ns/100ps

module msg_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    // ************************************************************
    // flags
    // ************************************************************
    // full and empty come from the count, so they never lie
    assign in_ready_out = (count_q != FULL_CNT);
    assign out_valid_out = (count_q != '0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // storage write, no reset needed on the array
    always_ff @(posedge ref_clk_in) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_in;
        end
    end

    // pointers and fill level
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            case ({push, pop})
                2'b10: count_q <= count_q + 1'b1;
                2'b01: count_q <= count_q - 1'b1;
                default: count_q <= count_q;
            endcase
        end
    end

    // popped word appears one cycle after the pop
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            out_data_out <= '0;
        end else if (pop) begin
            out_data_out <= mem_q[rd_ptr_q];
        end
    end

endmodule

// file: hdl/pci_message_doorbell_unit.sv
// file: doorbell, message register and queue logic of the messaging block
// Behaviour
// - host-set bits of the 32-bit inbound doorbell interrupt the core.
// - core-set bits of the 32-bit outbound doorbell interrupt the host; a write of zeros does not.
// - only host-written ones clear outbound doorbell bits; zeros do nothing.
// - two 32-bit inbound messages interrupt the core on a full host write.
// - two 32-bit outbound messages interrupt the host on a core write.
// - four fifo queues are kept: two inbound, two outbound.
// - inbound queues carry words host to core, outbound queues core to host.
// - both parties reach queues through access ports that move the words.
// - a word arriving in a queue interrupts the party it is meant for.
// - interrupt causes leave as level lines for the interrupt controller.
`timescale 1ns/100ps

module pci_message_doorbell_unit (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire messaging_block_pkg::req_t host_req_in,
    input wire messaging_block_pkg::req_t core_req_in,
    output logic [messaging_block_pkg::DATA_W-1:0] host_rdata_out,
    output logic host_rvalid_out,
    output logic host_refused_out,
    output logic [messaging_block_pkg::DATA_W-1:0] core_rdata_out,
    output logic core_rvalid_out,
    output logic core_refused_out,
    output logic host_irq_out,
    output logic core_irq_out
);

    // ************************************************************
    // helpers
    // ************************************************************
    // byte enables widened into a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // a write of the given target
    function automatic logic wr_hit(input messaging_block_pkg::req_t r,
                                    input messaging_block_pkg::target_t t);
        wr_hit = r.wr && (r.tgt == t);
    endfunction

    // a read of the given target
    function automatic logic rd_hit(input messaging_block_pkg::req_t r,
                                    input messaging_block_pkg::target_t t);
        rd_hit = r.rd && !r.wr && (r.tgt == t);
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    messaging_block_pkg::req_t req [messaging_block_pkg::NUM_DIR];
    logic [31:0] db_q [messaging_block_pkg::NUM_DIR];
    logic [31:0] msg_q [messaging_block_pkg::NUM_DIR][messaging_block_pkg::NUM_MSG];
    logic unread_q [messaging_block_pkg::NUM_DIR][messaging_block_pkg::NUM_MSG];
    logic [3:0] q_push;
    logic [3:0] q_ready;
    logic [3:0] q_valid;
    logic [3:0] q_pop;
    logic [31:0] q_data [messaging_block_pkg::NUM_Q];
    logic [31:0] q_wdata [messaging_block_pkg::NUM_Q];
    logic rd_p_q [messaging_block_pkg::NUM_DIR];
    logic rd_isq_q [messaging_block_pkg::NUM_DIR];
    logic [1:0] rd_qn_q [messaging_block_pkg::NUM_DIR];
    logic [31:0] rd_val_q [messaging_block_pkg::NUM_DIR];
    logic [31:0] rdata_q [messaging_block_pkg::NUM_DIR];
    logic rvalid_q [messaging_block_pkg::NUM_DIR];
    logic refused_q [messaging_block_pkg::NUM_DIR];
    logic irq_q [messaging_block_pkg::NUM_DIR];

    // side s writes into direction s and reads from the other one
    assign req[messaging_block_pkg::SIDE_HOST] = host_req_in;
    assign req[messaging_block_pkg::SIDE_CORE] = core_req_in;

    // ************************************************************
    // doorbells
    // ************************************************************
    // the writer sets bits, the reader clears by writing ones; a set in
    // the same cycle as a clear wins so no ring is lost
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            for (int d = 0; d < messaging_block_pkg::NUM_DIR; d++) begin
                db_q[d] <= messaging_block_pkg::WORD_RST;
            end
        end else begin
            for (int d = 0; d < messaging_block_pkg::NUM_DIR; d++) begin
                db_q[d] <= (db_q[d] & ~((wr_hit(req[1-d],
                                messaging_block_pkg::TGT_DB_CLEAR)
                                ? req[1-d].data & lane_mask(req[1-d].be)
                                : 32'h0000_0000)))
                         | (wr_hit(req[d], messaging_block_pkg::TGT_DOORBELL)
                                ? req[d].data & lane_mask(req[d].be)
                                : 32'h0000_0000);
            end
        end
    end

    // ************************************************************
    // message registers
    // ************************************************************
    // stored by byte lane; only a whole-word write marks a host message
    // unread, while any core write does (outbound has no width test)
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            for (int d = 0; d < messaging_block_pkg::NUM_DIR; d++) begin
                for (int i = 0; i < messaging_block_pkg::NUM_MSG; i++) begin
                    msg_q[d][i] <= messaging_block_pkg::WORD_RST;
                    unread_q[d][i] <= 1'b0;
                end
            end
        end else begin
            for (int d = 0; d < messaging_block_pkg::NUM_DIR; d++) begin
                for (int i = 0; i < messaging_block_pkg::NUM_MSG; i++) begin
                    if (wr_hit(req[d], messaging_block_pkg::TGT_MESSAGE)
                        && req[d].idx == 2'(i)) begin
                        msg_q[d][i] <= (msg_q[d][i] & ~lane_mask(req[d].be))
                            | (req[d].data & lane_mask(req[d].be));
                    end
                    if (wr_hit(req[d], messaging_block_pkg::TGT_MESSAGE)
                        && req[d].idx == 2'(i)
                        && (d == messaging_block_pkg::DIR_OUT
                            || req[d].be == messaging_block_pkg::BE_FULL))
                    begin
                        unread_q[d][i] <= 1'b1;
                    end else if (rd_hit(req[1-d],
                                        messaging_block_pkg::TGT_MESSAGE)
                                 && req[1-d].idx == 2'(i)) begin
                        unread_q[d][i] <= 1'b0;
                    end
                end
            end
        end
    end

    // ************************************************************
    // queues
    // ************************************************************
    // queues 0 and 1 are filled by the host, 2 and 3 by the core; a push
    // into a full queue is refused rather than stalling the bus side
    always_comb begin
        for (int q = 0; q < messaging_block_pkg::NUM_Q; q++) begin
            q_push[q] = wr_hit(req[q/2], messaging_block_pkg::TGT_QUEUE)
                        && req[q/2].idx == 2'(q);
            q_pop[q] = rd_hit(req[1-q/2], messaging_block_pkg::TGT_QUEUE)
                       && req[1-q/2].idx == 2'(q) && q_valid[q];
            q_wdata[q] = req[q/2].data;
        end
    end

    for (genvar g = 0; g < messaging_block_pkg::NUM_Q; g++) begin : g_queue
        msg_fifo #(
            .WIDTH(messaging_block_pkg::DATA_W),
            .DEPTH(messaging_block_pkg::Q_DEPTH)
        ) u_queue (
            .ref_clk_in(ref_clk_in),
            .rst_n_in(rst_n_in),
            .in_valid_in(q_push[g]),
            .in_ready_out(q_ready[g]),
            .in_data_in(q_wdata[g]),
            .out_valid_out(q_valid[g]),
            .out_ready_in(q_pop[g]),
            .out_data_out(q_data[g])
        );
    end

    // ************************************************************
    // read path and refusals
    // ************************************************************
    // stage one snapshots the register value or pops the queue, stage two
    // presents the word; a two-cycle answer keeps every read alike
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            for (int s = 0; s < messaging_block_pkg::NUM_DIR; s++) begin
                rd_p_q[s] <= 1'b0;
                rd_isq_q[s] <= 1'b0;
                rd_qn_q[s] <= 2'h0;
                rd_val_q[s] <= messaging_block_pkg::WORD_RST;
            end
        end else begin
            for (int s = 0; s < messaging_block_pkg::NUM_DIR; s++) begin
                rd_p_q[s] <= req[s].rd && !req[s].wr;
                rd_qn_q[s] <= req[s].idx;
                rd_isq_q[s] <= rd_hit(req[s], messaging_block_pkg::TGT_QUEUE)
                               && q_pop[req[s].idx];
                case (req[s].tgt)
                    messaging_block_pkg::TGT_DOORBELL:
                        rd_val_q[s] <= db_q[1-s];
                    messaging_block_pkg::TGT_DB_CLEAR:
                        rd_val_q[s] <= db_q[1-s];
                    messaging_block_pkg::TGT_MESSAGE:
                        rd_val_q[s] <= msg_q[1-s][req[s].idx[0]];
                    default:
                        rd_val_q[s] <= 32'h0000_0000;
                endcase
            end
        end
    end

    // answer stage; empty queue reads return zero, as do wrong-way ones unless the other side pops that queue in the same cycle
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            for (int s = 0; s < messaging_block_pkg::NUM_DIR; s++) begin
                rdata_q[s] <= messaging_block_pkg::WORD_RST;
                rvalid_q[s] <= 1'b0;
                refused_q[s] <= 1'b0;
            end
        end else begin
            for (int s = 0; s < messaging_block_pkg::NUM_DIR; s++) begin
                rvalid_q[s] <= rd_p_q[s];
                if (rd_p_q[s]) begin
                    rdata_q[s] <= rd_isq_q[s] ? q_data[rd_qn_q[s]]
                                              : rd_val_q[s];
                end
                refused_q[s] <= wr_hit(req[s], messaging_block_pkg::TGT_QUEUE)
                    && (req[s].idx[1] != 1'(s) || !q_ready[req[s].idx]);
            end
        end
    end

    // ************************************************************
    // interrupts
    // ************************************************************
    // level lines for the interrupt controller, one per receiving party
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            for (int d = 0; d < messaging_block_pkg::NUM_DIR; d++) begin
                irq_q[d] <= 1'b0;
            end
        end else begin
            for (int d = 0; d < messaging_block_pkg::NUM_DIR; d++) begin
                irq_q[d] <= (|db_q[d]) || unread_q[d][0] || unread_q[d][1]
                    || q_valid[2*d] || q_valid[2*d+1];
            end
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign host_rdata_out = rdata_q[messaging_block_pkg::SIDE_HOST];
    assign host_rvalid_out = rvalid_q[messaging_block_pkg::SIDE_HOST];
    assign host_refused_out = refused_q[messaging_block_pkg::SIDE_HOST];
    assign core_rdata_out = rdata_q[messaging_block_pkg::SIDE_CORE];
    assign core_rvalid_out = rvalid_q[messaging_block_pkg::SIDE_CORE];
    assign core_refused_out = refused_q[messaging_block_pkg::SIDE_CORE];
    assign host_irq_out = irq_q[messaging_block_pkg::DIR_OUT];
    assign core_irq_out = irq_q[messaging_block_pkg::DIR_IN];

endmodule

// file: verification/pci_message_doorbell_unit_chk.sv
// checker: port-level timing of the messaging block
`timescale 1ns/100ps

module pci_message_doorbell_unit_chk (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire messaging_block_pkg::req_t host_req_in,
    input wire messaging_block_pkg::req_t core_req_in,
    input wire logic host_rvalid_out,
    input wire logic host_refused_out,
    input wire logic core_rvalid_out,
    input wire logic core_refused_out,
    input wire logic host_irq_out,
    input wire logic core_irq_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    logic h_act1_q, h_act2_q, c_act1_q, c_act2_q;
    logic [1:0] h_t, c_t;
    logic h_w, c_w, h_r, c_r;
    // read wins only when no write rides in the same cycle
    assign h_t = host_req_in.tgt;
    assign c_t = core_req_in.tgt;
    assign h_w = host_req_in.wr;
    assign c_w = core_req_in.wr;
    assign h_r = host_req_in.rd && !host_req_in.wr;
    assign c_r = core_req_in.rd && !core_req_in.wr;

    // ************************************************************
    // request history
    // ************************************************************
    // a level may only drop two edges after its own side acted
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            h_act1_q <= 1'b0;
            h_act2_q <= 1'b0;
            c_act1_q <= 1'b0;
            c_act2_q <= 1'b0;
        end else begin
            h_act1_q <= h_w || host_req_in.rd;
            h_act2_q <= h_act1_q;
            c_act1_q <= c_w || core_req_in.rd;
            c_act2_q <= c_act1_q;
        end
    end

    chk_host_rd_answer: assert property (h_r |-> ##2 host_rvalid_out)
        else $error("host read answer late or missing");
    chk_core_rd_answer: assert property (c_r |-> ##2 core_rvalid_out)
        else $error("core read answer late or missing");
    chk_in_db_irq: assert property (h_w && h_t == 2'h0 &&
        host_req_in.be == 4'hf && host_req_in.data != '0 |-> ##2 core_irq_out)
        else $error("inbound doorbell gave no core interrupt");
    chk_out_db_irq: assert property (c_w && c_t == 2'h0 &&
        core_req_in.be == 4'hf && core_req_in.data != '0 |-> ##2 host_irq_out)
        else $error("outbound doorbell gave no host interrupt");
    chk_in_msg_irq: assert property (h_w && h_t == 2'h2 &&
        host_req_in.be == 4'hf |-> ##2 core_irq_out)
        else $error("inbound message gave no core interrupt");
    chk_out_msg_irq: assert property (c_w && c_t == 2'h2
        |-> ##2 host_irq_out)
        else $error("outbound message gave no host interrupt");
    chk_in_q_irq: assert property (h_w && h_t == 2'h3 &&
        !host_req_in.idx[1] |-> ##2 core_irq_out)
        else $error("inbound queue word gave no core interrupt");
    chk_host_wrong_q: assert property (h_w && h_t == 2'h3 &&
        host_req_in.idx[1] |=> host_refused_out)
        else $error("host push to outbound queue not refused");
    chk_core_wrong_q: assert property (c_w && c_t == 2'h3 &&
        !core_req_in.idx[1] |=> core_refused_out)
        else $error("core push to inbound queue not refused");
    chk_host_irq_drop: assert property ($fell(host_irq_out) |-> h_act2_q)
        else $error("host interrupt dropped without host action");
    chk_core_irq_drop: assert property ($fell(core_irq_out) |-> c_act2_q)
        else $error("core interrupt dropped without core action");

    cover property (host_refused_out);
    cover property (core_rvalid_out ##2 core_rvalid_out);
    cover property ($fell(host_irq_out));
endmodule

// file: verification/access_port_model.sv
// model of a party on one access port: remote host, or core stand-in
`timescale 1ns/100ps

module access_port_model (
    input wire logic ref_clk_in,
    output messaging_block_pkg::req_t req_out,
    input wire logic [messaging_block_pkg::DATA_W-1:0] rdata_in,
    input wire logic rvalid_in
);
    logic [31:0] last_q;

    initial begin
        req_out = '0;
        last_q = 32'h0000_0000;
    end

    // ************************************************************
    // requests
    // ************************************************************
    // one request, held until the edge that takes it
    task automatic put(input logic w, input logic r, input logic [1:0] t,
                       input logic [1:0] i, input logic [3:0] be,
                       input logic [31:0] d);
        req_out = '{w, r, messaging_block_pkg::target_t'(t), i, be, d};
        last_q = d;
        @(posedge ref_clk_in);
        #1;
    endtask

    // idle: released data shows the inverse of the last word, never a
    // stale copy that could pass for a real value
    task automatic idle(input int n);
        repeat (n) begin
            req_out = '{1'b0, 1'b0, messaging_block_pkg::TGT_DOORBELL,
                        2'h0, 4'h0, ~last_q};
            @(posedge ref_clk_in);
            #1;
        end
    endtask

    // read with a bounded wait for the answer pulse
    task automatic read(input logic [1:0] t, input logic [1:0] i,
                        output logic [31:0] d, output bit ok);
        put(1'b0, 1'b1, t, i, 4'hf, last_q);
        ok = 1'b0;
        d = '0;
        for (int k = 0; k < 5 && !ok; k++) begin
            idle(1);
            if (rvalid_in === 1'b1) begin
                ok = 1'b1;
                d = rdata_in;
            end
        end
    endtask
endmodule

// file: verification/pci_message_doorbell_unit_bench.sv
// testbench: doorbells, message registers and queues of the block
`timescale 1ns/100ps

module pci_message_doorbell_unit_bench;
    logic ref_clk_in, rst_n_in;
    messaging_block_pkg::req_t host_req, core_req;
    logic [31:0] host_rdata, core_rdata;
    logic host_rvalid, core_rvalid, host_refused, core_refused;
    logic host_irq, core_irq;
    int err_total = 0;
    int n_compared = 0;

    pci_message_doorbell_unit i_dut (.ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in), .host_req_in(host_req), .core_req_in(core_req),
        .host_rdata_out(host_rdata), .host_rvalid_out(host_rvalid),
        .host_refused_out(host_refused), .core_rdata_out(core_rdata),
        .core_rvalid_out(core_rvalid), .core_refused_out(core_refused),
        .host_irq_out(host_irq), .core_irq_out(core_irq));
    access_port_model i_host (.ref_clk_in(ref_clk_in), .req_out(host_req),
        .rdata_in(host_rdata), .rvalid_in(host_rvalid));
    access_port_model i_core (.ref_clk_in(ref_clk_in), .req_out(core_req),
        .rdata_in(core_rdata), .rvalid_in(core_rvalid));

    initial begin
        ref_clk_in = 1'b0;
        forever #10 ref_clk_in = ~ref_clk_in;
    end

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // codes: 0 doorbell, 1 doorbell clear, 2 message, 3 queue
    task automatic wr(input bit c, input logic [1:0] t, input logic [1:0] i,
                      input logic [3:0] be, input logic [31:0] d);
        if (c) begin
            i_core.put(1'b1, 1'b0, t, i, be, d);
            i_core.idle(1);
        end else begin
            i_host.put(1'b1, 1'b0, t, i, be, d);
            i_host.idle(1);
        end
    endtask

    // a lost answer counts as a mismatch and ends the run
    task automatic rd(input bit c, input logic [1:0] t, input logic [1:0] i,
                      input logic [31:0] exp, input string what);
        logic [31:0] d;
        bit ok;
        if (c) i_core.read(t, i, d, ok);
        else i_host.read(t, i, d, ok);
        if (!ok) begin
            err_total++;
            results();
        end else begin
            check(what, d, exp);
        end
    endtask

    // levels are registered two edges behind the cause; three is safe
    task automatic irqs(input logic h, input logic c);
        i_host.idle(3);
        check("host_irq", {31'h0, host_irq}, {31'h0, h});
        check("core_irq", {31'h0, core_irq}, {31'h0, c});
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_doorbells;
        wr(0, 2'h0, 2'h0, 4'hf, 32'h0000_0005);
        irqs(0, 1);
        rd(1, 2'h0, 2'h0, 32'h0000_0005, "in_db");
        wr(1, 2'h1, 2'h0, 4'hf, 32'h0000_0001);
        irqs(0, 1);
        wr(1, 2'h1, 2'h0, 4'hf, 32'h0000_0004);
        irqs(0, 0);
        wr(1, 2'h0, 2'h0, 4'hf, 32'h8000_0001);
        irqs(1, 0);
        wr(1, 2'h1, 2'h0, 4'hf, 32'h8000_0001);
        wr(0, 2'h1, 2'h0, 4'hf, 32'h0000_0000);
        irqs(1, 0);
        rd(0, 2'h0, 2'h0, 32'h8000_0001, "out_db");
        wr(0, 2'h1, 2'h0, 4'hf, 32'h0000_0001);
        irqs(1, 0);
        wr(0, 2'h1, 2'h0, 4'hf, 32'h8000_0000);
        irqs(0, 0);
    endtask

    // partial host write stores lanes but must not interrupt
    task automatic t_messages;
        wr(0, 2'h2, 2'h0, 4'hf, 32'h1111_1111);
        wr(0, 2'h2, 2'h1, 4'hf, 32'h2222_2222);
        irqs(0, 1);
        rd(1, 2'h2, 2'h0, 32'h1111_1111, "in_msg0");
        rd(1, 2'h2, 2'h1, 32'h2222_2222, "in_msg1");
        irqs(0, 0);
        wr(0, 2'h2, 2'h0, 4'h3, 32'haaaa_bbbb);
        irqs(0, 0);
        rd(1, 2'h2, 2'h0, 32'h1111_bbbb, "in_part");
        wr(1, 2'h2, 2'h1, 4'hf, 32'h3333_3333);
        irqs(1, 0);
        rd(0, 2'h2, 2'h1, 32'h3333_3333, "out_msg1");
        irqs(0, 0);
    endtask

    // fill queue 0 past full with the core stalled, then drain it
    task automatic t_queues;
        for (int i = 0; i < 17; i++) begin
            i_host.put(1'b1, 1'b0, 2'h3, 2'h0, 4'hf, 32'h100 + i);
        end
        // refusal pulses stand one cycle only, so look right after the take
        check("q_full", {31'h0, host_refused}, 32'h1);
        irqs(0, 1);
        i_host.put(1'b1, 1'b0, 2'h3, 2'h2, 4'hf, 32'h0000_0077);
        check("q_dir_h", {31'h0, host_refused}, 32'h1);
        i_host.idle(1);
        i_core.put(1'b1, 1'b0, 2'h3, 2'h0, 4'hf, 32'h0000_0078);
        check("q_dir_c", {31'h0, core_refused}, 32'h1);
        i_core.idle(1);
        for (int i = 0; i < 16; i++) begin
            rd(1, 2'h3, 2'h0, 32'h100 + i, "q0_pop");
        end
        rd(1, 2'h3, 2'h0, 32'h0000_0000, "q0_empty");
        irqs(0, 0);
        wr(0, 2'h3, 2'h1, 4'hf, 32'h0000_0051);
        rd(1, 2'h3, 2'h1, 32'h0000_0051, "q1");
        wr(1, 2'h3, 2'h2, 4'hf, 32'h0000_0052);
        irqs(1, 0);
        rd(0, 2'h3, 2'h2, 32'h0000_0052, "q2");
        wr(1, 2'h3, 2'h3, 4'hf, 32'h0000_0053);
        rd(0, 2'h3, 2'h3, 32'h0000_0053, "q3");
        irqs(0, 0);
    endtask

    initial begin
        rst_n_in = 1'b0;
        repeat (6) @(posedge ref_clk_in);
        #1;
        rst_n_in = 1'b1;
        irqs(0, 0);
        t_doorbells();
        t_messages();
        t_queues();
        results();
    end
endmodule

bind pci_message_doorbell_unit pci_message_doorbell_unit_chk i_chk (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .host_req_in(host_req_in), .core_req_in(core_req_in),
    .host_rvalid_out(host_rvalid_out), .host_refused_out(host_refused_out),
    .core_rvalid_out(core_rvalid_out), .core_refused_out(core_refused_out),
    .host_irq_out(host_irq_out), .core_irq_out(core_irq_out));
